// *** eeprom_read_master.sv ***
// Read master end with its receive FIFO.
// Assumes the data line is asynchronous to CLK; the master makes the
// link clock itself from CLK, so that clock needs no synchroniser.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------
module rx_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
         $error("FIFO depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW:0] wr_reg;
   logic [PW:0] wr_next;
   logic [PW:0] rd_reg;
   logic [PW:0] rd_next;
   logic push;
   logic pop;

   assign in_ready = (wr_reg - rd_reg) != (PW+1)'(DEPTH);
   assign out_valid = wr_reg != rd_reg;
   assign out_data = store[rd_reg[PW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      wr_next = wr_reg + (PW+1)'(push);
      rd_next = rd_reg + (PW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_reg[PW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end
endmodule

// ------------------------------------------------------------------
// Master
// ------------------------------------------------------------------
module eeprom_read_master
   import eeprom_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic CLK,
   input wire logic SRST,
   eeprom_link_if.host LINK,
   input wire logic REQ,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [7:0] REQ_LEN,
   output logic BUSY,
   output logic NO_ACK,
   output logic RD_VALID,
   input wire logic RD_READY,
   output logic [7:0] RD_DATA
);

   typedef enum logic [2:0] {
      H_IDLE      = 3'b000,
      H_START     = 3'b001,
      H_LOW       = 3'b010,
      H_HIGH      = 3'b011,
      H_STOP_LOW  = 3'b100,
      H_STOP_HIGH = 3'b101,
      H_BUF       = 3'b110
   } host_state_e;

   logic meta_reg;
   logic sda_s_reg;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         meta_reg <= 1'b1;
         sda_s_reg <= 1'b1;
      end else begin
         meta_reg <= LINK.sda;
         sda_s_reg <= meta_reg;
      end
   end

   host_state_e state_reg;
   host_state_e state_next;
   logic [TIMER_W-1:0] tmr_reg;
   logic [TIMER_W-1:0] tmr_next;
   logic [3:0] bit_reg;
   logic [3:0] bit_next;
   logic data_ph_reg;
   logic data_ph_next;
   logic [7:0] rem_reg;
   logic [7:0] rem_next;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic scl_reg;
   logic scl_next;
   logic oe_reg;
   logic oe_next;
   logic push_reg;
   logic push_next;
   logic nak_reg;
   logic nak_next;
   logic fifo_in_ready;

   // Level driven on the data line for the bit slot being entered
   function automatic logic drive_low(input logic data_ph,
                                      input logic [3:0] bit_idx,
                                      input logic [7:0] sh,
                                      input logic [7:0] rem);
      if (bit_idx == ACK_BIT) begin
         // Ack wants more; final byte left unacknowledged
         drive_low = data_ph && (rem > 8'h01);
      end else begin
         drive_low = !data_ph && !sh[7];
      end
   endfunction

   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      bit_next = bit_reg;
      data_ph_next = data_ph_reg;
      rem_next = rem_reg;
      sh_next = sh_reg;
      scl_next = scl_reg;
      oe_next = oe_reg;
      push_next = push_reg & ~fifo_in_ready;
      nak_next = nak_reg;
      if (tmr_reg != '0) begin
         tmr_next = tmr_reg - TIMER_W'(1);
      end
      case (state_reg)
         H_IDLE: begin
            if (REQ) begin
               // Start: data falls while the clock is high
               sh_next = {REQ_ADDR, 1'b1};
               rem_next = (REQ_LEN == 8'h00) ? 8'h01 : REQ_LEN;
               nak_next = 1'b0;
               oe_next = 1'b1;
               tmr_next = TIMER_W'(HD_STA_CYC);
               state_next = H_START;
            end
         end
         H_START: begin
            if (tmr_reg == '0) begin
               scl_next = 1'b0;
               bit_next = 4'h0;
               data_ph_next = 1'b0;
               oe_next = drive_low(1'b0, 4'h0, sh_reg, rem_reg);
               tmr_next = TIMER_W'(LOW_CYC);
               state_next = H_LOW;
            end
         end
         H_LOW: begin
            // A full FIFO holds the clock low before the ack slot
            if (tmr_reg == '0 && !push_reg) begin
               scl_next = 1'b1;
               tmr_next = TIMER_W'(HIGH_CYC);
               state_next = H_HIGH;
            end
         end
         H_HIGH: begin
            if (tmr_reg == '0) begin
               scl_next = 1'b0;
               tmr_next = TIMER_W'(LOW_CYC);
               state_next = H_LOW;
               bit_next = bit_reg + 4'h1;
               if (bit_reg == ACK_BIT) begin
                  bit_next = 4'h0;
                  data_ph_next = 1'b1;
                  if (!data_ph_reg && sda_s_reg) begin
                     nak_next = 1'b1;
                     state_next = H_STOP_LOW;
                  end else if (data_ph_reg) begin
                     rem_next = rem_reg - 8'h01;
                     if (rem_reg == 8'h01) begin
                        state_next = H_STOP_LOW;
                     end
                  end
               end else if (data_ph_reg) begin
                  sh_next = {sh_reg[6:0], sda_s_reg};
                  if (bit_reg == LAST_DATA_BIT) begin
                     push_next = 1'b1;
                  end
               end else begin
                  sh_next = {sh_reg[6:0], 1'b0};
               end
               if (state_next == H_STOP_LOW) begin
                  oe_next = 1'b1;
               end else if (bit_reg == LAST_DATA_BIT) begin
                  oe_next = drive_low(data_ph_reg, ACK_BIT, sh_reg, rem_reg);
               end else if (bit_reg == ACK_BIT) begin
                  oe_next = drive_low(1'b1, 4'h0, sh_reg, rem_reg);
               end else begin
                  oe_next = drive_low(data_ph_reg, bit_next,
                                      {sh_reg[6:0], 1'b0}, rem_reg);
               end
            end
         end
         H_STOP_LOW: begin
            if (tmr_reg == '0) begin
               scl_next = 1'b1;
               tmr_next = TIMER_W'(SU_STO_CYC);
               state_next = H_STOP_HIGH;
            end
         end
         H_STOP_HIGH: begin
            if (tmr_reg == '0) begin
               oe_next = 1'b0;
               tmr_next = TIMER_W'(BUF_CYC);
               state_next = H_BUF;
            end
         end
         H_BUF: begin
            if (tmr_reg == '0) begin
               state_next = H_IDLE;
            end
         end
         default: begin
            state_next = H_BUF;
            tmr_next = TIMER_W'(BUF_CYC);
            scl_next = 1'b1;
            oe_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         // Bus-free wait also applies after reset
         state_reg <= H_BUF;
         tmr_reg <= TIMER_W'(BUF_CYC);
         bit_reg <= 4'h0;
         data_ph_reg <= 1'b0;
         rem_reg <= 8'h00;
         sh_reg <= 8'h00;
         scl_reg <= 1'b1;
         oe_reg <= 1'b0;
         push_reg <= 1'b0;
         nak_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         bit_reg <= bit_next;
         data_ph_reg <= data_ph_next;
         rem_reg <= rem_next;
         sh_reg <= sh_next;
         scl_reg <= scl_next;
         oe_reg <= oe_next;
         push_reg <= push_next;
         nak_reg <= nak_next;
      end
   end

   rx_byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .srst(SRST),
      .in_valid(push_reg),
      .in_ready(fifo_in_ready),
      .in_data(sh_reg),
      .out_valid(RD_VALID),
      .out_ready(RD_READY),
      .out_data(RD_DATA)
   );

   assign LINK.scl = scl_reg;
   assign LINK.host_sda_o = 1'b0;
   assign LINK.host_sda_oe = oe_reg;
   assign BUSY = (state_reg != H_IDLE);
   assign NO_ACK = nak_reg;

endmodule
`default_nettype wire

// *** eeprom_pkg.sv ***
// Shared constants for the two-wire serial memory read path.
// Assumes a 250 MHz system clock on both ends of the link.
package eeprom_pkg;

   // ----------------------------------------------------------------
   // Array organisation
   // ----------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int MEM_BYTES = 128;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Timing, in ns as specified, and in 4 ns clock cycles
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int GLITCH_NS = 100;
   localparam int T_LOW_NS = 4700;
   localparam int T_HIGH_NS = 4000;
   localparam int T_HD_STA_NS = 4000;
   localparam int T_SU_STO_NS = 4700;
   localparam int T_BUF_NS = 4700;

   // Longest ignored pulse rounds down; least times round up
   localparam int GLITCH_CYC = GLITCH_NS / CLK_PERIOD_NS;
   localparam int LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HD_STA_CYC =
      (T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SU_STO_CYC =
      (T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int GCNT_W = 5;
   localparam int TIMER_W = 11;

   // ----------------------------------------------------------------
   // Bit counts within one byte slot
   // ----------------------------------------------------------------
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;

endpackage

// *** eeprom_link_if.sv ***
// Two-wire link between the read master and the memory slave.
// The master drives the clock; the data line is open drain on both
// ends and is resolved here with a pull-up.
`timescale 1ns/10ps
`default_nettype none
interface eeprom_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;

   // Line is high unless some end drives a low
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host(output scl, output host_sda_o, output host_sda_oe,
                input sda);
endinterface
`default_nettype wire

// *** eeprom_seq_read.sv ***
// Memory slave end: 128-byte array with sequential read over the link.
// Assumes the link pins are asynchronous to CLK; the array is filled
// from the local load port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Sequential read opens exactly like byte read
// - Master acknowledges a byte to want more
// - Each master acknowledge triggers the next byte
// - Master ends with no acknowledge, then stop
// - Byte n is followed by byte n+1
// - Read counter increments across all address bits
// - Counter wraps from 127 to 0, continues
// - Master keeps bus idle 4.7 us between transfers
// - Pulses of 100 ns or less are ignored
// - Start, seven-bit location, read bit, then acknowledge
// - Receiver pulls data low in ninth clock
// - No acknowledge stops sending, await stop
// - Stop is data rising with clock high
module eeprom_seq_read
   import eeprom_pkg::*;
#(
   parameter int DEPTH = MEM_BYTES
) (
   input wire logic CLK,
   input wire logic SRST,
   eeprom_link_if.dev LINK,
   input wire logic LOAD_EN,
   input wire logic [ADDR_W-1:0] LOAD_ADDR,
   input wire logic [7:0] LOAD_DATA,
   output logic STANDBY,
   output logic [ADDR_W-1:0] READ_ADDR
);

   generate
      if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
         $error("DEPTH must equal two to the address width");
      end
   endgenerate

   typedef enum logic [2:0] {
      D_IDLE      = 3'b000,
      D_ADDR      = 3'b001,
      D_ACK_WAIT  = 3'b010,
      D_ACK       = 3'b011,
      D_SEND      = 3'b100,
      D_WAIT_ACK  = 3'b101,
      D_ACKED     = 3'b110,
      D_WAIT_STOP = 3'b111
   } dev_state_e;

   // ----------------------------------------------------------------
   // Array
   // ----------------------------------------------------------------
   logic [7:0] mem [DEPTH];

   always_ff @(posedge CLK) begin
      if (LOAD_EN) begin
         mem[LOAD_ADDR] <= LOAD_DATA;
      end
   end

   // ----------------------------------------------------------------
   // Input synchronisers and glitch filters (index 0 clock, 1 data)
   // ----------------------------------------------------------------
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] filt_reg;
   logic [1:0] filt_next;
   logic [1:0] prev_reg;
   logic [GCNT_W-1:0] gcnt_reg [2];
   logic [GCNT_W-1:0] gcnt_next [2];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         filt_next[i] = filt_reg[i];
         gcnt_next[i] = '0;
         // A change must persist beyond the glitch window to pass
         if (sync_reg[i] != filt_reg[i]) begin
            if (gcnt_reg[i] == GCNT_W'(GLITCH_CYC)) begin
               filt_next[i] = sync_reg[i];
            end else begin
               gcnt_next[i] = gcnt_reg[i] + GCNT_W'(1);
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         meta_reg <= 2'h3;
         sync_reg <= 2'h3;
         filt_reg <= 2'h3;
         prev_reg <= 2'h3;
         gcnt_reg[0] <= '0;
         gcnt_reg[1] <= '0;
      end else begin
         meta_reg <= {LINK.sda, LINK.scl};
         sync_reg <= meta_reg;
         filt_reg <= filt_next;
         prev_reg <= filt_reg;
         gcnt_reg <= gcnt_next;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sda_in;

   assign sda_in = filt_reg[1];
   assign scl_rise = filt_reg[0] & ~prev_reg[0];
   assign scl_fall = ~filt_reg[0] & prev_reg[0];
   assign start_seen = filt_reg[0] & prev_reg[0] & prev_reg[1] & ~filt_reg[1];
   assign stop_seen = filt_reg[0] & prev_reg[0] & ~prev_reg[1] & filt_reg[1];

   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   dev_state_e state_reg;
   dev_state_e state_next;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic oe_reg;
   logic oe_next;
   logic standby_reg;
   logic standby_next;
   logic [7:0] rd_byte;

   assign rd_byte = mem[addr_reg];

   always_comb begin
      state_next = state_reg;
      sh_next = sh_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      oe_next = oe_reg;
      standby_next = standby_reg;
      if (stop_seen) begin
         state_next = D_IDLE;
         oe_next = 1'b0;
         standby_next = 1'b1;
      end else if (start_seen) begin
         state_next = D_ADDR;
         cnt_next = 4'h0;
         oe_next = 1'b0;
         standby_next = 1'b0;
      end else begin
         case (state_reg)
            D_IDLE: begin
               oe_next = 1'b0;
            end
            D_ADDR: begin
               if (scl_rise) begin
                  // Seven location bits, then the direction bit
                  sh_next = {sh_reg[6:0], sda_in};
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == LAST_DATA_BIT) begin
                     state_next = D_ACK_WAIT;
                  end
               end
            end
            D_ACK_WAIT: begin
               if (scl_fall) begin
                  if (sh_reg[0]) begin
                     // Drive the ninth-clock acknowledge
                     oe_next = 1'b1;
                     addr_next = sh_reg[7:1];
                     state_next = D_ACK;
                  end else begin
                     // Writes are not served by this read path
                     state_next = D_WAIT_STOP;
                  end
               end
            end
            D_ACK, D_ACKED: begin
               if (scl_fall) begin
                  // First byte as byte read, later ones per ack
                  sh_next = rd_byte;
                  oe_next = ~rd_byte[7];
                  // Full-width increment wraps 127 to 0
                  addr_next = addr_reg + ADDR_W'(1);
                  cnt_next = 4'h0;
                  state_next = D_SEND;
               end
            end
            D_SEND: begin
               if (scl_fall) begin
                  if (cnt_reg == LAST_DATA_BIT) begin
                     oe_next = 1'b0;
                     state_next = D_WAIT_ACK;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     oe_next = ~sh_reg[6];
                     cnt_next = cnt_reg + 4'h1;
                  end
               end
            end
            D_WAIT_ACK: begin
               if (scl_rise) begin
                  if (!sda_in) begin
                     state_next = D_ACKED;
                  end else begin
                     state_next = D_WAIT_STOP;
                  end
               end
            end
            D_WAIT_STOP: begin
               oe_next = 1'b0;
            end
            default: begin
               state_next = D_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= D_IDLE;
         sh_reg <= DATA_RESET;
         cnt_reg <= 4'h0;
         addr_reg <= ADDR_RESET;
         oe_reg <= 1'b0;
         standby_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         sh_reg <= sh_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         oe_reg <= oe_next;
         standby_reg <= standby_next;
      end
   end

   // Open drain: only ever pulls low
   assign LINK.dev_sda_o = 1'b0;
   assign LINK.dev_sda_oe = oe_reg;
   assign STANDBY = standby_reg;
   assign READ_ADDR = addr_reg;

endmodule
`default_nettype wire

// *** serial_eeprom_monitor.sv ***
// Checker for the two-wire link between the read master and the slave.
// Assumes it sits beside the link interface and runs on the master CLK.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_monitor
   import eeprom_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic sda
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   // ---------------------------------------------------------------
   // Line events and phase counters
   // ---------------------------------------------------------------
   logic scl_reg, sda_reg, quiet_reg, quiet_next;
   logic start_ev, stop_ev, rise_ev, fall_ev, ack_slot;
   logic [TIMER_W-1:0] low_reg, low_next, high_reg, high_next;
   logic [TIMER_W-1:0] idle_reg, idle_next;
   logic [7:0] rise_reg, rise_next;

   always_comb begin
      start_ev = scl && scl_reg && sda_reg && !sda;
      stop_ev = scl && scl_reg && !sda_reg && sda;
      rise_ev = scl && !scl_reg;
      fall_ev = !scl && scl_reg;
      ack_slot = rise_ev && (rise_reg % 8'h09 == 8'h08);
      low_next = scl ? '0 : (&low_reg ? low_reg : low_reg + 1'b1);
      high_next = !scl ? '0 : (&high_reg ? high_reg : high_reg + 1'b1);
      idle_next = stop_ev ? '0 : (&idle_reg ? idle_reg : idle_reg + 1'b1);
      rise_next = start_ev ? 8'h00 : rise_reg + {7'h00, rise_ev};
      // Slave may drive only from its address acknowledge until a
      // refused byte, a stop or a new start
      quiet_next = quiet_reg;
      if (rise_ev && rise_reg == 8'h07) begin
         quiet_next = 1'b0;
      end
      if ((ack_slot && sda) || start_ev || stop_ev) begin
         quiet_next = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         quiet_reg <= 1'b1;
         low_reg <= '0;
         high_reg <= '0;
         idle_reg <= '1;
         rise_reg <= 8'h00;
      end else begin
         scl_reg <= scl;
         sda_reg <= sda;
         quiet_reg <= quiet_next;
         low_reg <= low_next;
         high_reg <= high_next;
         idle_reg <= idle_next;
         rise_reg <= rise_next;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   dev_open_drain_a: assert property (dev_sda_o == 1'b0)
      else $error("slave data output not low");
   host_open_drain_a: assert property (host_sda_o == 1'b0)
      else $error("master data output not low");
   dev_low_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("slave changed data while clock high");
   addr_ack_a: assert property (rise_ev && rise_reg == 8'h08
      |-> dev_sda_oe && !sda) else $error("address not acknowledged");
   ack_release_a: assert property (ack_slot && rise_reg > 8'h08
      |-> !dev_sda_oe) else $error("slave held data in ack slot");
   dev_quiet_a: assert property (quiet_reg
      |-> !dev_sda_oe) else $error("slave drove data while it must be silent");
   bus_free_a: assert property (start_ev |-> idle_reg >= BUF_CYC)
      else $error("start too soon after stop");
   low_time_a: assert property (rise_ev |-> low_reg >= LOW_CYC)
      else $error("clock low phase too short");
   high_time_a: assert property (fall_ev |-> high_reg >= HIGH_CYC)
      else $error("clock high phase too short");

   cover property (start_ev);
   cover property (ack_slot && rise_reg == 8'h11 && !sda);
   cover property (ack_slot && rise_reg > 8'h08 && sda);
   cover property (stop_ev);
endmodule
`default_nettype wire

// *** serial_eeprom_sequential_read_tb_top.sv ***
// Bench: master and slave joined by the link, one wrapping read.
// Assumes both ends share CLK; the master makes the link clock.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_sequential_read_tb_top
   import eeprom_pkg::*;
;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic LOAD_EN = 1'b0;
   logic REQ = 1'b0;
   logic RD_READY = 1'b0;
   logic [6:0] LOAD_ADDR = 7'h00;
   logic [6:0] REQ_ADDR = 7'h00;
   logic [7:0] LOAD_DATA = 8'h00;
   logic [7:0] REQ_LEN = 8'h00;
   logic STANDBY, BUSY, NO_ACK, RD_VALID;
   logic [6:0] READ_ADDR;
   logic [7:0] RD_DATA;
   logic [7:0] mem [0:127];
   logic [7:0] got [$];
   logic wire_bits [$];
   logic scl_prev = 1'b1;
   logic [31:0] seed = 32'h6E542970;
   logic [31:0] rdy_seed = 32'h6E542970;
   int failures = 0;
   int cmp_count = 0;

   always #2 CLK = ~CLK;

   eeprom_link_if eeprom_link_if_i ();
   eeprom_seq_read eeprom_seq_read_i (.CLK(CLK), .SRST(SRST),
      .LINK(eeprom_link_if_i), .LOAD_EN(LOAD_EN), .LOAD_ADDR(LOAD_ADDR),
      .LOAD_DATA(LOAD_DATA), .STANDBY(STANDBY), .READ_ADDR(READ_ADDR));
   eeprom_read_master #(.FIFO_DEPTH(16)) eeprom_read_master_i (.CLK(CLK),
      .SRST(SRST), .LINK(eeprom_link_if_i), .REQ(REQ), .REQ_ADDR(REQ_ADDR),
      .REQ_LEN(REQ_LEN), .BUSY(BUSY), .NO_ACK(NO_ACK), .RD_VALID(RD_VALID),
      .RD_READY(RD_READY), .RD_DATA(RD_DATA));
   serial_eeprom_monitor serial_eeprom_monitor_i (.CLK(CLK), .SRST(SRST),
      .scl(eeprom_link_if_i.scl), .host_sda_o(eeprom_link_if_i.host_sda_o),
      .host_sda_oe(eeprom_link_if_i.host_sda_oe),
      .dev_sda_o(eeprom_link_if_i.dev_sda_o),
      .dev_sda_oe(eeprom_link_if_i.dev_sda_oe), .sda(eeprom_link_if_i.sda));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [6:0] exp_loc(input logic [6:0] b, input int i);
      return b + i[6:0];
   endfunction

   // Bits seen on the wire at clock rises, first bit first
   function automatic logic [7:0] wire_byte(input int s);
      logic [7:0] b;
      b = 8'h00;
      for (int j = 0; j < 8; j++) begin
         b = {b[6:0], wire_bits[s + j]};
      end
      return b;
   endfunction

   task automatic check(input logic [31:0] val, input logic [31:0] exp);
      cmp_count++;
      if (val !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, val, exp);
      end
   endtask

   task automatic load_byte(input logic [6:0] a, input logic [7:0] d);
      mem[a] = d;
      LOAD_EN <= 1'b1;
      LOAD_ADDR <= a;
      LOAD_DATA <= d;
      @(negedge CLK);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Wire observer and stalling sink
   // ---------------------------------------------------------------
   always @(negedge CLK) begin
      if (eeprom_link_if_i.scl === 1'b1 && scl_prev === 1'b0) begin
         wire_bits.push_back(eeprom_link_if_i.sda);
      end
      scl_prev <= eeprom_link_if_i.scl;
      rdy_seed = lfsr_next(rdy_seed);
      // Ready set here meets the valid and data of the coming edge
      if (RD_VALID === 1'b1 && rdy_seed[3] === 1'b1) begin
         got.push_back(RD_DATA);
      end
      RD_READY <= rdy_seed[3];
   end

   initial begin
      repeat (95000) @(posedge CLK);
      failures++;
      finish_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge CLK);
      @(negedge CLK);
      SRST <= 1'b0;
      check(STANDBY, 32'h1);
      for (int i = 0; i < MEM_BYTES; i++) begin
         seed = lfsr_next(seed);
         load_byte(i[6:0], seed[7:0]);
      end
      // Lopsided patterns make a reversed bit order visible
      load_byte(7'h7F, 8'h01);
      load_byte(7'h00, 8'hFE);
      LOAD_EN <= 1'b0;
      for (int n = 0; n < 2000 && BUSY !== 1'b0; n++) @(negedge CLK);
      check(BUSY, 32'h0);
      REQ_ADDR <= 7'h7E;
      REQ_LEN <= 8'h03;
      REQ <= 1'b1;
      @(negedge CLK);
      REQ <= 1'b0;
      repeat (3000) @(negedge CLK);
      check(STANDBY, 32'h0);
      for (int n = 0; n < 90000 && BUSY !== 1'b0; n++) @(negedge CLK);
      check(BUSY, 32'h0);
      repeat (40) @(negedge CLK);
      check(got.size(), 32'h3);
      for (int i = 0; i < 3; i++) begin
         check(got[i], mem[exp_loc(7'h7E, i)]);
      end
      // Last rise is the stop's clock, with data still held low
      check(wire_bits.size(), 32'd37);
      check(wire_bits[36], 32'h0);
      check(wire_byte(0), 8'hFD);
      check(wire_bits[8], 32'h0);
      for (int k = 0; k < 3; k++) begin
         check(wire_byte(9 + 9 * k), mem[exp_loc(7'h7E, k)]);
         check(wire_bits[17 + 9 * k], k == 2);
      end
      check(STANDBY, 32'h1);
      check(NO_ACK, 32'h0);
      check(READ_ADDR, exp_loc(7'h7E, 3));
      finish_test();
   end
endmodule
`default_nettype wire
